//--- slpio_pkg.sv
// Package of register addresses, reset values and mode codes for the shared LCD I/O ports.
package slpio_pkg;

	// ------------------------------------------------------------
	// Register indices; the byte address is four times the index
	// ------------------------------------------------------------
	localparam logic [15:0] IDX_P6_LATCH = 16'hffd9;
	localparam logic [15:0] IDX_P6_DIR = 16'hffe9;
	localparam logic [15:0] IDX_P6_PULLUP = 16'hffe3;
	localparam logic [15:0] IDX_P7_LATCH = 16'hffda;
	localparam logic [15:0] IDX_P7_DIR = 16'hffea;
	localparam logic [15:0] IDX_LCD_CTRL = 16'hffc0;

	// ------------------------------------------------------------
	// Byte addresses on the APB
	// ------------------------------------------------------------
	localparam logic [31:0] ADDR_P6_LATCH = {14'h0000, IDX_P6_LATCH, 2'h0};
	localparam logic [31:0] ADDR_P6_DIR = {14'h0000, IDX_P6_DIR, 2'h0};
	localparam logic [31:0] ADDR_P6_PULLUP = {14'h0000, IDX_P6_PULLUP, 2'h0};
	localparam logic [31:0] ADDR_P7_LATCH = {14'h0000, IDX_P7_LATCH, 2'h0};
	localparam logic [31:0] ADDR_P7_DIR = {14'h0000, IDX_P7_DIR, 2'h0};
	localparam logic [31:0] ADDR_LCD_CTRL = {14'h0000, IDX_LCD_CTRL, 2'h0};

	// ------------------------------------------------------------
	// Reset values and fixed read values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_LATCH = 8'h00;
	localparam logic [7:0] RST_DIR = 8'h00;
	localparam logic [7:0] RST_PULLUP = 8'h00;
	localparam logic [3:0] RST_SHARE = 4'h0;
	localparam logic [7:0] DIR_READ_VALUE = 8'hff;

	// ------------------------------------------------------------
	// Field of the segment-share select inside the LCD control word
	// ------------------------------------------------------------
	localparam int SHARE_LSB = 0;
	localparam int SHARE_W = 4;

	// ------------------------------------------------------------
	// Power mode codes presented by the system controller
	// ------------------------------------------------------------
	localparam logic [2:0] PM_ACTIVE = 3'h0;
	localparam logic [2:0] PM_SUBACTIVE = 3'h1;
	localparam logic [2:0] PM_SLEEP = 3'h2;
	localparam logic [2:0] PM_SUBSLEEP = 3'h3;
	localparam logic [2:0] PM_WATCH = 3'h4;
	localparam logic [2:0] PM_STANDBY = 3'h5;

endpackage

//--- slpio_top.sv
// Shared LCD I/O ports: APB register file, segment sharing and pin drive.
//
// Functional notes
// - First port high nibble: 011x/1xxx select segments.
// - First port low nibble: 0111/1xxx select segments.
// - Second port high nibble: 01xx/1xxx select segments.
// - Second port low nibble: 0101/011x/1xxx select segments.
// - First port: hi-Z reset, standby hi-Z except pull-up pins, hold, else run.
// - First port standby with pull-up drives high.
// - Second port: hi-Z reset/standby, hold, else run.
// - Pull-up on only when direction 0, control 1.
// - First port pull-ups disabled after reset.
// - Second port read, output bit returns latch.
// - Second port read, input bit returns pin.
// - Second port latch resets to zero.
// - Direction bit 1 output, 0 input.
// - Direction and latch act only in I/O mode; direction gates the pull-up in segment mode too.
// - Second port direction write-only, reads ones.
// - Second port direction resets to zero.
// - Two ports of eight independent pins each.
// - First port read: latch if output, else pin.
// - First port direction write-only, reads ones, resets zero.
// - First port pull-up control readable, resets zero.

// ------------------------------------------------------------
// Pin bank: one port of pins with its drive and hold logic
// ------------------------------------------------------------
module slpio_pin_bank #(
	parameter int W = 8,
	parameter bit HAS_PULLUP = 1'b0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [2:0] mode,
	input wire logic share_hi,
	input wire logic share_lo,
	input wire logic [W-1:0] lcd_in,
	input wire logic [W-1:0] latch,
	input wire logic [W-1:0] dir,
	input wire logic [W-1:0] pu_ctrl,
	output logic [W-1:0] pin_out,
	output logic [W-1:0] pin_oe_n,
	output logic [W-1:0] pu_on
);

	logic [W-1:0] share_mask;
	logic [W-1:0] func_out;
	logic [W-1:0] func_oe_n;
	logic [W-1:0] pu_want;
	logic [W-1:0] next_out;
	logic [W-1:0] next_oe_n;
	logic [W-1:0] next_pu;
	logic in_standby;
	logic in_hold;

	// Segment selection is made per nibble of the bank.
	assign share_mask = {{(W/2){share_hi}}, {(W/2){share_lo}}};

	assign pu_want = HAS_PULLUP ? (pu_ctrl & ~dir) : '0;

	// latch and direction only in I/O mode.
	assign func_out = (share_mask & lcd_in) | (~share_mask & latch);
	assign func_oe_n = ~(share_mask | dir);

	assign in_standby = (mode == slpio_pkg::PM_STANDBY);
	assign in_hold = (mode == slpio_pkg::PM_SLEEP) | (mode == slpio_pkg::PM_SUBSLEEP) |
		(mode == slpio_pkg::PM_WATCH);

	// The pin state per power mode. Unknown codes are treated as running, so
	// a glitching mode bus can never freeze the pins silently.
	always_comb
	begin
		next_out = func_out;
		next_oe_n = func_oe_n;
		next_pu = pu_want;
		case (1'b1)
			in_standby:
			begin
				next_out = pu_want;
				next_oe_n = ~pu_want;
				next_pu = pu_want;
			end
			in_hold:
			begin
				next_out = pin_out;
				next_oe_n = pin_oe_n;
				next_pu = pu_on;
			end
			default:
			begin
				next_out = func_out;
				next_oe_n = func_oe_n;
				next_pu = pu_want;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_out <= '0;
			pin_oe_n <= '1;
			pu_on <= '0;
		end
		else
		begin
			pin_out <= next_out;
			pin_oe_n <= next_oe_n;
			pu_on <= next_pu;
		end
	end

endmodule

// ------------------------------------------------------------
// Top level: APB slave with both ports
// ------------------------------------------------------------
module slpio_top #(
	parameter int PORT_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [2:0] power_mode,
	input wire logic [2*PORT_W-1:0] lcd_drive_out,
	input wire logic [PORT_W-1:0] first_port_pin_in,
	output logic [PORT_W-1:0] first_port_pin_out,
	output logic [PORT_W-1:0] first_port_pin_oe_n,
	output logic [PORT_W-1:0] first_port_pullup_on,
	input wire logic [PORT_W-1:0] second_port_pin_in,
	output logic [PORT_W-1:0] second_port_pin_out,
	output logic [PORT_W-1:0] second_port_pin_oe_n
);

	// each port keeps its own latch and direction bits.
	logic [PORT_W-1:0] port6_output_latch;
	logic [PORT_W-1:0] port6_direction;
	logic [PORT_W-1:0] port6_pullup_enable;
	logic [PORT_W-1:0] port7_output_latch;
	logic [PORT_W-1:0] port7_direction;
	logic [slpio_pkg::SHARE_W-1:0] lcd_pin_share_select;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	wire hit_p6_latch = (paddr == slpio_pkg::ADDR_P6_LATCH);
	wire hit_p6_dir = (paddr == slpio_pkg::ADDR_P6_DIR);
	wire hit_p6_pu = (paddr == slpio_pkg::ADDR_P6_PULLUP);
	wire hit_p7_latch = (paddr == slpio_pkg::ADDR_P7_LATCH);
	wire hit_p7_dir = (paddr == slpio_pkg::ADDR_P7_DIR);
	wire hit_lcd = (paddr == slpio_pkg::ADDR_LCD_CTRL);
	wire hit_any = hit_p6_latch | hit_p6_dir | hit_p6_pu | hit_p7_latch | hit_p7_dir | hit_lcd;

	// One wait state: the first access cycle captures read data, the second
	// completes. This keeps prdata a flop at the cost of one cycle per access.
	wire access = psel & penable;
	wire first_cycle = access & ~pready;

	// writes land at the completing edge.
	wire wr_ok = access & pready & pwrite & pstrb[0] & hit_any;
	wire wr_p6_latch = wr_ok & hit_p6_latch;
	wire wr_p6_dir = wr_ok & hit_p6_dir;
	wire wr_p6_pu = wr_ok & hit_p6_pu;
	wire wr_p7_latch = wr_ok & hit_p7_latch;
	wire wr_p7_dir = wr_ok & hit_p7_dir;
	wire wr_lcd = wr_ok & hit_lcd;
	wire [PORT_W-1:0] wr_byte = pwdata[PORT_W-1:0];

	// ------------------------------------------------------------
	// Read selection
	// ------------------------------------------------------------
	// first port read mixes latch and pin.
	wire [PORT_W-1:0] rd_p6 = (port6_direction & port6_output_latch) |
		(~port6_direction & first_port_pin_in);
	wire [PORT_W-1:0] rd_p7 = (port7_direction & port7_output_latch) |
		(~port7_direction & second_port_pin_in);
	wire [PORT_W-1:0] rd_dir = slpio_pkg::DIR_READ_VALUE;
	wire [PORT_W-1:0] rd_lcd = {{(PORT_W-slpio_pkg::SHARE_W){1'b0}}, lcd_pin_share_select};
	wire [PORT_W-1:0] rd_sel = hit_p6_latch ? rd_p6 :
		(hit_p6_dir | hit_p7_dir) ? rd_dir :
		hit_p6_pu ? port6_pullup_enable :
		hit_p7_latch ? rd_p7 :
		hit_lcd ? rd_lcd : '0;
	wire [31:0] next_rdata = pwrite ? 32'h00000000 : {{(32-PORT_W){1'b0}}, rd_sel};

	// ------------------------------------------------------------
	// APB response
	// ------------------------------------------------------------
	// The answer flops; an unmapped address completes with an error.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= first_cycle;
			if (first_cycle)
			begin
				prdata <= next_rdata;
				pslverr <= ~hit_any;
			end
		end
	end

	// ------------------------------------------------------------
	// First port registers
	// ------------------------------------------------------------
	// Output latch of the first port.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			port6_output_latch <= slpio_pkg::RST_LATCH;
		else if (wr_p6_latch)
			port6_output_latch <= wr_byte;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			port6_direction <= slpio_pkg::RST_DIR;
		else if (wr_p6_dir)
			port6_direction <= wr_byte;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			port6_pullup_enable <= slpio_pkg::RST_PULLUP;
		else if (wr_p6_pu)
			port6_pullup_enable <= wr_byte;
	end

	// ------------------------------------------------------------
	// Second port registers
	// ------------------------------------------------------------
	// latch clears at reset.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			port7_output_latch <= slpio_pkg::RST_LATCH;
		else if (wr_p7_latch)
			port7_output_latch <= wr_byte;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			port7_direction <= slpio_pkg::RST_DIR;
		else if (wr_p7_dir)
			port7_direction <= wr_byte;
	end

	// ------------------------------------------------------------
	// LCD port control
	// ------------------------------------------------------------
	// Segment-share select; other fields of the LCD controller live elsewhere.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			lcd_pin_share_select <= slpio_pkg::RST_SHARE;
		else if (wr_lcd)
			lcd_pin_share_select <= wr_byte[slpio_pkg::SHARE_LSB +: slpio_pkg::SHARE_W];
	end

	// ------------------------------------------------------------
	// Segment-share decode per nibble
	// ------------------------------------------------------------
	wire [3:0] ss = lcd_pin_share_select;
	wire seg6_hi = ss[3] | (ss[2] & ss[1]);
	wire seg6_lo = ss[3] | (ss == 4'h7);
	wire seg7_hi = ss[3] | ss[2];
	wire seg7_lo = ss[3] | (ss[2] & (ss[1] | ss[0]));

	// ------------------------------------------------------------
	// Pin banks
	// ------------------------------------------------------------
	// First port carries pull-ups; its segments are the low half of the bus.
	slpio_pin_bank #(
		.W(PORT_W),
		.HAS_PULLUP(1'b1)
	) u_first_bank (
		.clk(pclk),
		.rst_n(presetn),
		.mode(power_mode),
		.share_hi(seg6_hi),
		.share_lo(seg6_lo),
		.lcd_in(lcd_drive_out[PORT_W-1:0]),
		.latch(port6_output_latch),
		.dir(port6_direction),
		.pu_ctrl(port6_pullup_enable),
		.pin_out(first_port_pin_out),
		.pin_oe_n(first_port_pin_oe_n),
		.pu_on(first_port_pullup_on)
	);

	// Second port has no pull-ups, so its bank keeps the pull-up path tied off.
	slpio_pin_bank #(
		.W(PORT_W),
		.HAS_PULLUP(1'b0)
	) u_second_bank (
		.clk(pclk),
		.rst_n(presetn),
		.mode(power_mode),
		.share_hi(seg7_hi),
		.share_lo(seg7_lo),
		.lcd_in(lcd_drive_out[2*PORT_W-1:PORT_W]),
		.latch(port7_output_latch),
		.dir(port7_direction),
		.pu_ctrl({PORT_W{1'b0}}),
		.pin_out(second_port_pin_out),
		.pin_oe_n(second_port_pin_oe_n),
		.pu_on()
	);

endmodule

//--- slpio_asserts.sv
// Checker of bus timing and pin states for the shared LCD I/O ports.
module slpio_asserts #(
	parameter int PORT_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic [2:0] power_mode,
	input wire logic [PORT_W-1:0] first_port_pin_out,
	input wire logic [PORT_W-1:0] first_port_pin_oe_n,
	input wire logic [PORT_W-1:0] first_port_pullup_on,
	input wire logic [PORT_W-1:0] second_port_pin_out,
	input wire logic [PORT_W-1:0] second_port_pin_oe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Steps of a transfer, one sample, and of the low-power modes, two samples so outputs have settled.
	sequence s_wait;
		psel && penable && !pready;
	endsequence
	sequence s_hold;
		(power_mode inside {[slpio_pkg::PM_SLEEP : slpio_pkg::PM_WATCH]}) [*2];
	endsequence
	sequence s_stby;
		(power_mode == slpio_pkg::PM_STANDBY) [*2];
	endsequence
	AST_ONE_WAIT: assert property (s_wait |=> pready)
		else $error("pready not after one wait state");
	AST_PULSE: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	AST_UPPER_ZERO: assert property (pready |-> prdata[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
	AST_DIR6_ONES: assert property (pready && !pwrite && paddr == slpio_pkg::ADDR_P6_DIR
		|-> prdata[7:0] == 8'hff) else $error("first direction read not all ones");
	AST_DIR7_ONES: assert property (pready && !pwrite && paddr == slpio_pkg::ADDR_P7_DIR
		|-> prdata[7:0] == 8'hff) else $error("second direction read not all ones");
	AST_RESET_HIZ: assert property ($rose(presetn) |-> &first_port_pin_oe_n
		&& &second_port_pin_oe_n && first_port_pullup_on == '0) else $error("pins not idle");
	AST_STBY_P7: assert property (s_stby |-> &second_port_pin_oe_n)
		else $error("second port driven in standby");
	AST_STBY_P6: assert property (s_stby |-> first_port_pin_oe_n == ~first_port_pullup_on
		&& (first_port_pin_out & first_port_pullup_on) == first_port_pullup_on)
		else $error("first port standby level wrong");
	AST_HOLD: assert property (s_hold |-> $stable(first_port_pin_out)
		&& $stable(first_port_pin_oe_n) && $stable(second_port_pin_out)
		&& $stable(second_port_pin_oe_n) && $stable(first_port_pullup_on))
		else $error("pins changed in a hold mode");
endmodule

bind slpio_top slpio_asserts #(.PORT_W(PORT_W)) u_asserts (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .prdata, .pready, .power_mode, .first_port_pin_out, .first_port_pin_oe_n,
	.first_port_pullup_on, .second_port_pin_out, .second_port_pin_oe_n);

//--- slpio_board.sv
// Board model: outside levels seen by both ports and pull-up loading on the first port.
module slpio_board (
	input wire logic [7:0] p6_out,
	input wire logic [7:0] p6_oe_n,
	input wire logic [7:0] p6_pu,
	input wire logic [7:0] p7_out,
	input wire logic [7:0] p7_oe_n,
	input wire logic [7:0] ext6,
	input wire logic [7:0] ext7,
	output logic [7:0] p6_in,
	output logic [7:0] p7_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// A released pin goes to its pull-up when on, else to the board level, never the old value.
	assign p6_in = (~p6_oe_n & p6_out) | (p6_oe_n & (p6_pu | ext6));
	assign p7_in = (~p7_oe_n & p7_out) | (p7_oe_n & ext7);
endmodule

//--- test_shared_lcd_io_ports.sv
// Self-checking testbench for the shared LCD I/O ports.
module test_shared_lcd_io_ports;
	timeunit 1ns;
	timeprecision 1ps;
	`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
		$display("Error %s expected %h seen %h", n, e, g); end end
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] paddr = '0, pwdata = '0, prdata, r;
	logic [3:0] pstrb = 4'hf, msh;
	logic pready, pslverr;
	logic [2:0] power_mode = '0;
	logic [15:0] lcd = '0, sg;
	logic [7:0] p6i, p6o, p6e, p6u, p7i, p7o, p7e, ext6 = '0, ext7 = '0, pin6, pin7;
	logic [7:0] m6l, m6d, m6p, m7l, m7d, e6o, e6e, e7o, e7e, epu;
	int seed = 32'hfe21, err_total = 0, n_checks = 0, cyc = 0;
	slpio_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .power_mode, .lcd_drive_out(lcd),
		.first_port_pin_in(p6i), .first_port_pin_out(p6o), .first_port_pin_oe_n(p6e),
		.first_port_pullup_on(p6u), .second_port_pin_in(p7i), .second_port_pin_out(p7o),
		.second_port_pin_oe_n(p7e));
	slpio_board board_u (.p6_out(p6o), .p6_oe_n(p6e), .p6_pu(p6u), .p7_out(p7o),
		.p7_oe_n(p7e), .ext6, .ext7, .p6_in(p6i), .p7_in(p7i));
	// Free-running bus clock and a cycle ceiling so a stuck handshake cannot hang the run.
	always #5 pclk = ~pclk;
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			err_total++;
			stop_test();
		end
	end
	// Segment masks per share code: second port in 15:8, first port in 7:0.
	function automatic logic [15:0] segm(input logic [3:0] s);
		// Each nibble's segment codes form one upper range of the share code.
		segm = {{4{s >= 4'h4}}, {4{s >= 4'h5}},
			{4{s >= 4'h6}}, {4{s >= 4'h7}}};
	endfunction
	// One transfer; a spare edge at the end keeps requests from reusing one time step.
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic check_regs();
		sg = segm(msh);
		pin6 = (sg[7:0] & lcd[7:0]) | (~sg[7:0] & (m6p & ~m6d | ext6));
		pin7 = (sg[15:8] & lcd[15:8]) | (~sg[15:8] & ext7);
		apb(1'b0, slpio_pkg::ADDR_P6_LATCH, '0);
		`CHK("p6 read", {24'h0, m6d & m6l | ~m6d & pin6}, r)
		apb(1'b0, slpio_pkg::ADDR_P7_LATCH, '0);
		`CHK("p7 read", {24'h0, m7d & m7l | ~m7d & pin7, 1'b0}, {r, pslverr})
		apb(1'b0, slpio_pkg::ADDR_P6_DIR, '0);
		`CHK("p6 dir", 32'hff, r)
		apb(1'b0, slpio_pkg::ADDR_P7_DIR, '0);
		`CHK("p7 dir", 32'hff, r)
		apb(1'b0, slpio_pkg::ADDR_P6_PULLUP, '0);
		`CHK("pull-up reg", {24'h0, m6p}, r)
		apb(1'b0, slpio_pkg::ADDR_LCD_CTRL, '0);
		`CHK("share reg", {28'h0, msh}, r)
		apb(1'b0, 32'h4, '0);
		`CHK("unmapped", 1'b1, pslverr)
	endtask
	// Expected pins follow the mode; a hold mode keeps the last expectation unchanged.
	task automatic expect_pins();
		sg = segm(msh);
		epu = m6p & ~m6d;
		if (power_mode == slpio_pkg::PM_STANDBY)
		begin
			e6e = ~epu;
			e6o = epu;
			e7e = 8'hff;
			e7o = 8'h00;
		end
		else if (!(power_mode inside {[slpio_pkg::PM_SLEEP : slpio_pkg::PM_WATCH]}))
		begin
			e6e = ~(sg[7:0] | m6d);
			e6o = (sg[7:0] & lcd[7:0] | ~sg[7:0] & m6l) & ~e6e;
			e7e = ~(sg[15:8] | m7d);
			e7o = (sg[15:8] & lcd[15:8] | ~sg[15:8] & m7l) & ~e7e;
		end
		repeat (2) @(posedge pclk);
		`CHK("p6 pins", {e6e, e6o}, {p6e, p6o & ~p6e})
		`CHK("p7 pins", {e7e, e7o}, {p7e, p7o & ~p7e})
		`CHK("pull-up on", epu, p6u)
	endtask
	task automatic do_reset();
		presetn <= 1'b0;
		repeat (16) @(posedge pclk);
		`CHK("reset pins", 24'hffff00, {p6e, p7e, p6u})
		{m6l, m6d, m6p, m7l, m7d, msh} = 44'h0;
		presetn <= 1'b1;
		@(posedge pclk);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		do_reset();
		check_regs();
		expect_pins();
		$display("reset test done");
		for (int i = 0; i < 16; i++)
		begin
			msh = i[3:0];
			{m6l, m6d, m6p, m7l, m7d} = 40'({$random(seed), $random(seed)});
			{lcd, ext6, ext7} <= 32'($random(seed));
			apb(1'b1, slpio_pkg::ADDR_LCD_CTRL, {28'h0, msh});
			apb(1'b1, slpio_pkg::ADDR_P6_LATCH, {24'h0, m6l});
			apb(1'b1, slpio_pkg::ADDR_P6_DIR, {24'h0, m6d});
			apb(1'b1, slpio_pkg::ADDR_P6_PULLUP, {24'h0, m6p});
			apb(1'b1, slpio_pkg::ADDR_P7_LATCH, {24'h0, m7l});
			apb(1'b1, slpio_pkg::ADDR_P7_DIR, {24'h0, m7d});
			expect_pins();
			check_regs();
		end
		pstrb <= 4'he;
		apb(1'b1, slpio_pkg::ADDR_P6_PULLUP, {24'h0, ~m6p});
		pstrb <= 4'hf;
		check_regs();
		$display("share code test done");
		// Codes 6 and 7 are unused by the system and must behave as active.
		for (int m = 1; m < 9; m++)
		begin
			power_mode <= 3'(m % 8);
			{lcd, ext6, ext7} <= 32'($random(seed));
			@(posedge pclk);
			expect_pins();
		end
		$display("power mode test done");
		do_reset();
		check_regs();
		$display("second reset test done");
		stop_test();
	end
endmodule
